/* hw/sfr_bank_regs.svh */
`ifndef SFR_BANK_REGS_SVH
`define SFR_BANK_REGS_SVH
// ==========================================
// Register offsets
`define SFR_P0 8'h80
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
`define SFR_POWER_CONTROL 8'h87
`define SFR_TIMER_CONTROL 8'h88
`define SFR_TIMER_MODE_CONTROL 8'h89
`define SFR_TL0 8'h8a
`define SFR_TL1 8'h8b
`define SFR_TH0 8'h8c
`define SFR_TH1 8'h8d
`define SFR_P1 8'h90
`define SFR_SERIAL_CONTROL 8'h98
`define SFR_SERIAL_BUFFER 8'h99
`define SFR_P2 8'ha0
`define SFR_IE 8'ha8
`define SFR_P3 8'hb0
`define SFR_IP 8'hb8
`define SFR_TIMER2_CONTROL 8'hc8
`define SFR_TIMER2_CAPTURE_LOW 8'hca
`define SFR_TIMER2_CAPTURE_HIGH 8'hcb
`define SFR_TL2 8'hcc
`define SFR_TH2 8'hcd
`define SFR_PSW 8'hd0
`define SFR_ACC 8'he0
`define SFR_B 8'hf0
// ==========================================
// Field positions
`define PSW_CY 7
`define PSW_AC 6
`define PSW_OV 2
`define PSW_PAR 0
`define PSW_WMASK 8'hfc
`define T2_CAPSEL 0
`define T2_RUN 2
// ==========================================
// Reset values
`define SP_RESET 8'h07
`define PORT_RESET 8'hff
`define ZERO_RESET 8'h00
// ==========================================
// Timing, in oscillator periods
`define OSC_PER_CYCLE 12
`define PH_S1P2 4'h1
`define PH_S2P1 4'h2
`define PH_S4P2 4'h7
`define PH_S5P1 4'h8
`define PH_S6P2 4'hb
`endif

/* hw/sfr_bank_pkg.sv */
package sfr_bank_pkg;
	typedef enum logic [1:0] {
		CLS_ONE = 2'h0,
		CLS_TWO = 2'h1,
		CLS_MULDIV = 2'h2,
		CLS_XMOVE = 2'h3
	} instr_cls_t;
	typedef enum logic [2:0] {
		ST_FIRST = 3'b001,
		ST_MORE = 3'b010,
		ST_XDATA = 3'b100
	} seq_state_t;
	typedef struct packed {
		logic two_byte;
		instr_cls_t cls;
	} instr_info_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic indirect;
		logic pin;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic wdata;
	} bit_req_t;
	typedef struct packed {
		logic wr;
		logic cy;
		logic ac;
		logic ov;
	} alu_flags_t;
endpackage

/* hw/sfr_bank.sv */
// How it works
// (RL1) Machine cycle is six states, twelve periods
// (RL2) Each phase one period, advances every period
// (RL3) Phase clocks run at half oscillator rate
// (RL4) Strobe high S1P2-S2P1 and S4P2-S5P1
// (RL5) Opcode latched at S1P2 starts execution
// (RL6) S4 fetch: operand or discarded, no increment
// (RL7) Execution completes end of S6P2, last cycle
// (RL8) Multiply/divide four cycles, others at most two
// (RL9) Two fetches per cycle, skipped in data move
// (RL10) Stack pointer pre-increments before each store
// (RL11) Reset loads stack pointer with 07H
// (RL12) Data pointer: one 16-bit or two bytes
// (RL13) Serial buffer: write transmits, read receives
// (RL14) Trigger transition captures timer-2 count
// (RL15) Reload mode loads counter from capture pair
// (RL16) Parity flag tracks accumulator every cycle
// (RL17) Two status bits select register bank
// (RL18) Status word carry, aux, user, overflow layout
// (RL19) Listed registers reachable bytewise and bitwise
// (RL20) Timer-2 registers only on enhanced variant
// (RL21) Each timer counts in a byte pair; timers 0 and 1 here are only TL/TH latches, and only timer 2 counts
// (RL22) Four port latches in the bank
// (RL23) Registers reached only by direct addressing
// (RL24) Bit access only for addresses ending 000B
// (RL25) Unassigned addresses read zero, ignore writes
`timescale 1ns/1ps
`include "sfr_bank_regs.svh"
module sfr_bank #(
	parameter bit HAS_TIMER2 = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire sfr_bank_pkg::sfr_req_t SFR_REQ,
	input wire sfr_bank_pkg::bit_req_t BIT_REQ,
	input wire sfr_bank_pkg::instr_info_t INSTR_INFO,
	input wire sfr_bank_pkg::alu_flags_t ALU_FLAGS,
	input wire logic [7:0] CODE_BYTE,
	input wire logic [31:0] PORT_PIN,
	input wire logic TIMER2_CAPTURE_TRIGGER_PIN,
	input wire logic PUSH_REQ,
	input wire logic POP_REQ,
	input wire logic DATA_POINTER_LOAD,
	input wire logic [15:0] DATA_POINTER_LOAD_VALUE,
	input wire logic DATA_POINTER_INC,
	input wire logic RX_LOAD,
	input wire logic [7:0] RX_BYTE,
	output logic [7:0] SFR_RDATA,
	output logic BIT_RDATA,
	output logic ALE,
	output logic FETCH,
	output logic PC_INC,
	output logic EXEC_DONE,
	output logic XDATA_STROBE,
	output logic [7:0] INSTR_REG,
	output logic [7:0] OPERAND,
	output logic [3:0] PHASE_COUNT,
	output logic PHASE_CLK,
	output logic [7:0] STACK_ADDR,
	output logic [15:0] DATA_POINTER,
	output logic [31:0] PORT_LATCH,
	output logic [7:0] BANK_BASE,
	output logic [15:0] TIMER0_COUNT,
	output logic [15:0] TIMER1_COUNT,
	output logic [15:0] TIMER2_COUNT,
	output logic [7:0] TX_DATA,
	output logic TX_START
);
	// ==========================================
	// Plain latch registers
	localparam int NPLAIN = 16;
	localparam int I_TIMER_CONTROL = 5;
	localparam int I_TL0 = 7;
	localparam int I_TL1 = 8;
	localparam int I_TH0 = 9;
	localparam int I_TH1 = 10;
	localparam int I_ACC = 14;
	localparam logic [7:0] PLAIN_ADDR [NPLAIN] = '{
		`SFR_P0, `SFR_P1, `SFR_P2, `SFR_P3, `SFR_POWER_CONTROL, `SFR_TIMER_CONTROL,
		`SFR_TIMER_MODE_CONTROL, `SFR_TL0, `SFR_TL1, `SFR_TH0, `SFR_TH1, `SFR_SERIAL_CONTROL,
		`SFR_IE, `SFR_IP, `SFR_ACC, `SFR_B};
	localparam logic [7:0] PLAIN_RST [NPLAIN] = '{
		`PORT_RESET, `PORT_RESET, `PORT_RESET, `PORT_RESET,
		`ZERO_RESET, `ZERO_RESET, `ZERO_RESET, `ZERO_RESET,
		`ZERO_RESET, `ZERO_RESET, `ZERO_RESET, `ZERO_RESET,
		`ZERO_RESET, `ZERO_RESET, `ZERO_RESET, `ZERO_RESET};

	logic [7:0] plain_reg [NPLAIN];
	logic [7:0] sp_reg, dpl_reg, dph_reg, psw_reg, rx_buf_reg;
	logic [7:0] timer2_control_reg, rcap_l_reg, rcap_h_reg, tl2_reg, th2_reg;
	logic [7:0] pin_s1_reg [4];
	logic [7:0] pin_s2_reg [4];
	logic [7:0] code_s1_reg, code_s2_reg;
	logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] cyc_left_reg;
	sfr_bank_pkg::seq_state_t state_reg, state_next;
	sfr_bank_pkg::instr_info_t info_reg;

	// ==========================================
	// Address decoding
	function automatic logic is_t2(input logic [7:0] a);
		return HAS_TIMER2 && (a == `SFR_TIMER2_CONTROL || a == `SFR_TIMER2_CAPTURE_LOW ||
			a == `SFR_TIMER2_CAPTURE_HIGH || a == `SFR_TL2 || a == `SFR_TH2); // RL20
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = is_t2(a) || a == `SFR_SP || a == `SFR_DPL ||
			a == `SFR_DPH || a == `SFR_PSW || a == `SFR_SERIAL_BUFFER;
		for (int i = 0; i < NPLAIN; i++) begin
			hit = hit || (a == PLAIN_ADDR[i]);
		end
		return hit;
	endfunction

	// Only the listed registers; not every 000B address is populated
	function automatic logic is_bitable(input logic [7:0] a);
		return a == `SFR_ACC || a == `SFR_B || a == `SFR_PSW ||
			a == `SFR_P0 || a == `SFR_P1 || a == `SFR_P2 ||
			a == `SFR_P3 || a == `SFR_IP || a == `SFR_IE ||
			a == `SFR_TIMER_CONTROL || a == `SFR_SERIAL_CONTROL ||
			(HAS_TIMER2 && a == `SFR_TIMER2_CONTROL); // RL19
	endfunction

	wire [7:0] psw_view = {psw_reg[7:2], 1'b0, psw_reg[`PSW_PAR]};

	// Unmapped and absent addresses fall through to zero
	function automatic logic [7:0] sfr_value(input logic [7:0] a,
		input logic pin);
		logic [7:0] v;
		v = 8'h00; // RL25
		for (int i = 0; i < NPLAIN; i++) begin
			if (a == PLAIN_ADDR[i]) begin
				v = plain_reg[i];
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (pin && a == PLAIN_ADDR[i]) begin
				v = pin_s2_reg[i];
			end
		end
		if (a == `SFR_SP) v = sp_reg;
		if (a == `SFR_DPL) v = dpl_reg;
		if (a == `SFR_DPH) v = dph_reg;
		if (a == `SFR_PSW) v = psw_view;
		if (a == `SFR_SERIAL_BUFFER) v = rx_buf_reg; // RL13
		if (is_t2(a)) begin
			if (a == `SFR_TIMER2_CONTROL) v = timer2_control_reg;
			if (a == `SFR_TIMER2_CAPTURE_LOW) v = rcap_l_reg;
			if (a == `SFR_TIMER2_CAPTURE_HIGH) v = rcap_h_reg;
			if (a == `SFR_TL2) v = tl2_reg;
			if (a == `SFR_TH2) v = th2_reg;
		end
		return v;
	endfunction

	// ==========================================
	// Write path: byte writes win over bit writes
	wire byte_wr = SFR_REQ.wr && !SFR_REQ.indirect; // RL23
	wire [7:0] bit_byte = {BIT_REQ.addr[7:3], 3'b000}; // RL24
	wire [2:0] bit_pos = BIT_REQ.addr[2:0];
	wire bit_ok = BIT_REQ.addr[7] && is_bitable(bit_byte); // RL24
	// Process form: the function reads registers that are not arguments
	logic [7:0] bit_old;
	always_comb bit_old = sfr_value(bit_byte, 1'b0);
	wire [7:0] bit_merged = (bit_old & ~(8'h01 << bit_pos)) |
		({7'h00, BIT_REQ.wdata} << bit_pos);
	wire wr_en = byte_wr || (BIT_REQ.wr && bit_ok);
	wire [7:0] w_addr = byte_wr ? SFR_REQ.addr : bit_byte;
	wire [7:0] w_data = byte_wr ? SFR_REQ.wdata : bit_merged;

	function automatic logic wr_hit(input logic [7:0] a);
		return wr_en && w_addr == a && is_mapped(a); // RL25
	endfunction

	// ==========================================
	// Synchronisers for pins and code bus
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			code_s1_reg <= 8'h00;
			code_s2_reg <= 8'h00;
			trig_s1_reg <= 1'b1;
			trig_s2_reg <= 1'b1;
			trig_s3_reg <= 1'b1;
		end else if (CLK_EN) begin
			code_s1_reg <= CODE_BYTE;
			code_s2_reg <= code_s1_reg;
			trig_s1_reg <= TIMER2_CAPTURE_TRIGGER_PIN;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			always_ff @(posedge REF_CLK or negedge RST_N) begin
				if (!RST_N) begin
					pin_s1_reg[g] <= 8'hff;
					pin_s2_reg[g] <= 8'hff;
				end else if (CLK_EN) begin
					pin_s1_reg[g] <= PORT_PIN[g*8 +: 8];
					pin_s2_reg[g] <= pin_s1_reg[g];
				end
			end
		end
		// Ports, timer bytes, control and data registers
		for (g = 0; g < NPLAIN; g++) begin : g_plain
			always_ff @(posedge REF_CLK or negedge RST_N) begin
				if (!RST_N) begin
					plain_reg[g] <= PLAIN_RST[g]; // RL22
				end else if (CLK_EN && wr_hit(PLAIN_ADDR[g])) begin
					plain_reg[g] <= w_data; // RL19
				end
			end
		end
	endgenerate

	// ==========================================
	// Stack pointer, data pointer, status word
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sp_reg <= `SP_RESET; // RL11
			STACK_ADDR <= 8'h00;
		end else if (CLK_EN) begin
			if (wr_hit(`SFR_SP)) begin
				sp_reg <= w_data;
			end else if (PUSH_REQ) begin
				sp_reg <= sp_reg + 8'h01; // RL10
				STACK_ADDR <= sp_reg + 8'h01; // RL10
			end else if (POP_REQ) begin
				sp_reg <= sp_reg - 8'h01;
				STACK_ADDR <= sp_reg;
			end
		end
	end

	wire [15:0] data_pointer_plus = {dph_reg, dpl_reg} + 16'h0001;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dpl_reg <= 8'h00;
			dph_reg <= 8'h00;
		end else if (CLK_EN) begin
			if (DATA_POINTER_LOAD) begin
				{dph_reg, dpl_reg} <= DATA_POINTER_LOAD_VALUE; // RL12
			end else if (DATA_POINTER_INC) begin
				{dph_reg, dpl_reg} <= data_pointer_plus; // RL12
			end else begin
				if (wr_hit(`SFR_DPL)) dpl_reg <= w_data; // RL12
				if (wr_hit(`SFR_DPH)) dph_reg <= w_data; // RL12
			end
		end
	end

	// Parity lags the accumulator by one oscillator period
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			psw_reg <= 8'h00;
		end else if (CLK_EN) begin
			if (wr_hit(`SFR_PSW)) begin
				psw_reg[7:2] <= w_data[7:2]; // RL18
			end
			if (ALU_FLAGS.wr) begin
				psw_reg[`PSW_CY] <= ALU_FLAGS.cy; // RL18
				psw_reg[`PSW_AC] <= ALU_FLAGS.ac; // RL18
				psw_reg[`PSW_OV] <= ALU_FLAGS.ov; // RL18
			end
			psw_reg[`PSW_PAR] <= ^plain_reg[I_ACC]; // RL16
		end
	end

	// ==========================================
	// Serial buffer pair
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			TX_DATA <= 8'h00;
			TX_START <= 1'b0;
			rx_buf_reg <= 8'h00;
		end else if (CLK_EN) begin
			TX_START <= wr_hit(`SFR_SERIAL_BUFFER); // RL13
			if (wr_hit(`SFR_SERIAL_BUFFER)) TX_DATA <= w_data; // RL13
			if (RX_LOAD) rx_buf_reg <= RX_BYTE; // RL13
		end
	end

	// ==========================================
	// Timer 2 capture and reload
	wire [15:0] t2_count = {th2_reg, tl2_reg}; // RL21
	wire t2_tick = cnt_reg == `PH_S6P2 && timer2_control_reg[`T2_RUN];
	wire t2_ovf = t2_tick && t2_count == 16'hffff;
	wire t2_cap = HAS_TIMER2 && timer2_control_reg[`T2_CAPSEL] &&
		trig_s3_reg && !trig_s2_reg;
	wire t2_reload = t2_ovf && !timer2_control_reg[`T2_CAPSEL];

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			timer2_control_reg <= 8'h00;
			rcap_l_reg <= 8'h00;
			rcap_h_reg <= 8'h00;
			tl2_reg <= 8'h00;
			th2_reg <= 8'h00;
		end else if (CLK_EN) begin
			if (wr_hit(`SFR_TIMER2_CONTROL)) timer2_control_reg <= w_data;
			// Capture event wins over a same-cycle write
			if (t2_cap) begin
				{rcap_h_reg, rcap_l_reg} <= t2_count; // RL14
			end else begin
				if (wr_hit(`SFR_TIMER2_CAPTURE_LOW)) rcap_l_reg <= w_data;
				if (wr_hit(`SFR_TIMER2_CAPTURE_HIGH)) rcap_h_reg <= w_data;
			end
			if (wr_hit(`SFR_TL2) || wr_hit(`SFR_TH2)) begin
				if (wr_hit(`SFR_TL2)) tl2_reg <= w_data;
				if (wr_hit(`SFR_TH2)) th2_reg <= w_data;
			end else if (t2_reload) begin
				{th2_reg, tl2_reg} <= {rcap_h_reg, rcap_l_reg}; // RL15
			end else if (t2_tick) begin
				{th2_reg, tl2_reg} <= t2_count + 16'h0001; // RL21
			end
		end
	end

	// ==========================================
	// Read port
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SFR_RDATA <= 8'h00;
			BIT_RDATA <= 1'b0;
		end else if (CLK_EN) begin
			SFR_RDATA <= (SFR_REQ.rd && !SFR_REQ.indirect) ?
				sfr_value(SFR_REQ.addr, SFR_REQ.pin) : 8'h00; // RL23
			BIT_RDATA <= BIT_REQ.rd && bit_ok && bit_old[bit_pos]; // RL24
		end
	end

	// ==========================================
	// Machine-cycle sequencer
	wire last_phase = cnt_reg == `PH_S6P2;
	wire final_cycle = cyc_left_reg == 2'h0;
	wire first = state_reg == sfr_bank_pkg::ST_FIRST;
	wire [1:0] extra_cycles =
		INSTR_INFO.cls == sfr_bank_pkg::CLS_MULDIV ? 2'h3 : // RL8
		INSTR_INFO.cls == sfr_bank_pkg::CLS_ONE ? 2'h0 : 2'h1; // RL8
	wire in_ale = cnt_next == `PH_S1P2 || cnt_next == `PH_S2P1 ||
		cnt_next == `PH_S4P2 || cnt_next == `PH_S5P1; // RL4
	wire fetch_slot = cnt_next == `PH_S1P2 || cnt_next == `PH_S4P2;

	assign cnt_next = last_phase ? 4'h0 : cnt_reg + 4'h1; // RL2

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			sfr_bank_pkg::ST_FIRST,
			sfr_bank_pkg::ST_MORE,
			sfr_bank_pkg::ST_XDATA: begin
				if (last_phase && final_cycle) begin
					state_next = sfr_bank_pkg::ST_FIRST;
				end else if (last_phase) begin
					state_next = info_reg.cls == sfr_bank_pkg::CLS_XMOVE ?
						sfr_bank_pkg::ST_XDATA : sfr_bank_pkg::ST_MORE;
				end
			end
			default: state_next = sfr_bank_pkg::ST_FIRST;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_reg <= 4'h0;
			PHASE_CLK <= 1'b0;
			state_reg <= sfr_bank_pkg::ST_FIRST;
			cyc_left_reg <= 2'h0;
			info_reg <= '0;
		end else if (CLK_EN) begin
			cnt_reg <= cnt_next; // RL1
			PHASE_CLK <= cnt_next[0]; // RL3
			state_reg <= state_next;
			if (first && cnt_reg == `PH_S1P2) begin
				info_reg <= INSTR_INFO;
				cyc_left_reg <= extra_cycles; // RL8
			end else if (last_phase && !final_cycle) begin
				cyc_left_reg <= cyc_left_reg - 2'h1;
			end
		end
	end

	// Strobes line up with the phase they name
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ALE <= 1'b0;
			FETCH <= 1'b0;
			PC_INC <= 1'b0;
			EXEC_DONE <= 1'b0;
			XDATA_STROBE <= 1'b0;
			INSTR_REG <= 8'h00;
			OPERAND <= 8'h00;
		end else if (CLK_EN) begin
			ALE <= in_ale; // RL4
			FETCH <= fetch_slot &&
				state_next != sfr_bank_pkg::ST_XDATA; // RL9
			PC_INC <= first && (cnt_next == `PH_S1P2 ||
				(cnt_next == `PH_S4P2 && info_reg.two_byte)); // RL6
			EXEC_DONE <= cnt_next == `PH_S6P2 && final_cycle; // RL7
			XDATA_STROBE <= state_next == sfr_bank_pkg::ST_XDATA; // RL9
			if (first && cnt_reg == `PH_S1P2) begin
				INSTR_REG <= code_s2_reg; // RL5
			end
			if (first && cnt_reg == `PH_S4P2 && info_reg.two_byte) begin
				OPERAND <= code_s2_reg; // RL6
			end
		end
	end

	assign PHASE_COUNT = cnt_reg;
	assign DATA_POINTER = {dph_reg, dpl_reg};
	assign PORT_LATCH = {plain_reg[3], plain_reg[2], plain_reg[1],
		plain_reg[0]};
	assign BANK_BASE = {3'b000, psw_reg[4:3], 3'b000}; // RL17
	assign TIMER0_COUNT = {plain_reg[I_TH0], plain_reg[I_TL0]};
	assign TIMER1_COUNT = {plain_reg[I_TH1], plain_reg[I_TL1]};
	assign TIMER2_COUNT = t2_count;

	// ==========================================
	// Checks
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	property p_cycle_wrap;
		CLK_EN && cnt_reg == `PH_S6P2 |=> cnt_reg == 4'h0;
	endproperty
	a_cycle_wrap: assert property (p_cycle_wrap) // RL1
		else $error("cycle did not wrap after S6P2");

	property p_phase_step;
		CLK_EN && cnt_reg != `PH_S6P2 |=> cnt_reg == $past(cnt_reg) + 4'h1;
	endproperty
	a_phase_step: assert property (p_phase_step) // RL2
		else $error("phase did not advance");

	property p_ale_shape;
		CLK_EN && cnt_reg == 4'h0 ##1 CLK_EN |-> ALE ##1 ALE;
	endproperty
	a_ale_shape: assert property (p_ale_shape) // RL4
		else $error("strobe not high S1P2 to S2P1");

	property p_opcode;
		CLK_EN && first && cnt_reg == `PH_S1P2 |=>
			INSTR_REG == $past(code_s2_reg);
	endproperty
	a_opcode: assert property (p_opcode) // RL5
		else $error("opcode not latched at S1P2");

	property p_done;
		EXEC_DONE |-> cnt_reg == `PH_S6P2 && cyc_left_reg == 2'h0;
	endproperty
	a_done: assert property (p_done) // RL7
		else $error("completion outside final S6P2");

	property p_xdata;
		XDATA_STROBE |-> !FETCH;
	endproperty
	a_xdata: assert property (p_xdata) // RL9
		else $error("fetch during external data move");

	property p_push;
		CLK_EN && PUSH_REQ && !wr_hit(`SFR_SP) |=>
			sp_reg == $past(sp_reg) + 8'h01 && STACK_ADDR == sp_reg;
	endproperty
	a_push: assert property (p_push) // RL10
		else $error("stack pointer not pre-incremented");

	property p_parity;
		CLK_EN |=> psw_reg[`PSW_PAR] == ^$past(plain_reg[I_ACC]);
	endproperty
	a_parity: assert property (p_parity) // RL16
		else $error("parity flag wrong");

	property p_unmapped;
		CLK_EN && SFR_REQ.rd &&
			(SFR_REQ.indirect || !is_mapped(SFR_REQ.addr)) |=>
			SFR_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) // RL25
		else $error("unmapped or indirect read not zero");
endmodule

/* verif/code_mem_model.sv */
`timescale 1ns/1ps
// ==========================================
// Code memory on the far side of the code bus
module code_mem_model (
	input wire logic [3:0] phase_count,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand,
	output logic [7:0] code_byte
);
	// Opcode held S6-S2, operand S3-S5: covers the two-flop sync lag
	assign code_byte = (phase_count >= 4'h4 && phase_count <= 4'h9) ?
		operand : opcode;
endmodule

/* verif/mcu_core_sfr_bank_and_cycle_timing_tb.sv */
`timescale 1ns/1ps
module mcu_core_sfr_bank_and_cycle_timing_tb;
	// ==========================================
	// Signals and reference model state
	logic ref_clk = 1'b0;
	logic rst_n, clk_en, trig, push_req, pop_req, data_pointer_load, data_pointer_inc, rx_load;
	sfr_bank_pkg::sfr_req_t sfr_req;
	sfr_bank_pkg::bit_req_t bit_req;
	sfr_bank_pkg::instr_info_t instr_info;
	sfr_bank_pkg::alu_flags_t alu_flags;
	logic [7:0] code_byte, rx_byte, sfr_rdata, instr_reg, operand_q;
	logic [7:0] stack_addr, bank_base, tx_data, rdat, v, opb, opd, eir, eopd;
	logic [31:0] port_pin, port_latch;
	logic [15:0] data_pointer_val, dp, t0, t1, t2;
	logic bit_rdata, ale, fetch, pc_inc, exec_done, xstb, phase_clk, tx_start;
	logic brd, txs;
	logic [3:0] phase_count;
	logic [7:0] shadow [256];
	logic [7:0] regs [26] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88,
		8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h98, 8'h99, 8'ha0,
		8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0,
		8'he0, 8'hf0};
	int mismatches = 0;
	int total_checks = 0;
	int cnt, cyc, ncyc, cls, two, idx, i;
	integer seed = 81321;
	wire xm = (cls == 3) && (cyc == 1);

	always #10 ref_clk = ~ref_clk;

	sfr_bank #(.HAS_TIMER2(1'b1)) u_dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en),
		.SFR_REQ(sfr_req), .BIT_REQ(bit_req), .INSTR_INFO(instr_info),
		.ALU_FLAGS(alu_flags), .CODE_BYTE(code_byte), .PORT_PIN(port_pin),
		.TIMER2_CAPTURE_TRIGGER_PIN(trig), .PUSH_REQ(push_req),
		.POP_REQ(pop_req), .DATA_POINTER_LOAD(data_pointer_load), .DATA_POINTER_LOAD_VALUE(data_pointer_val),
		.DATA_POINTER_INC(data_pointer_inc), .RX_LOAD(rx_load), .RX_BYTE(rx_byte),
		.SFR_RDATA(sfr_rdata), .BIT_RDATA(bit_rdata), .ALE(ale),
		.FETCH(fetch), .PC_INC(pc_inc), .EXEC_DONE(exec_done),
		.XDATA_STROBE(xstb), .INSTR_REG(instr_reg), .OPERAND(operand_q),
		.PHASE_COUNT(phase_count), .PHASE_CLK(phase_clk),
		.STACK_ADDR(stack_addr), .DATA_POINTER(dp), .PORT_LATCH(port_latch),
		.BANK_BASE(bank_base), .TIMER0_COUNT(t0), .TIMER1_COUNT(t1),
		.TIMER2_COUNT(t2), .TX_DATA(tx_data), .TX_START(tx_start));

	code_mem_model u_mem (.phase_count(phase_count), .opcode(opb),
		.operand(opd), .code_byte(code_byte));

	// ==========================================
	// Cycle sequencer model
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt = 0;
			cyc = 0;
			ncyc = 1;
			cls = 0;
			two = 0;
			eir = 8'h00;
			eopd = 8'h00;
		end else if (clk_en) begin
			if (cnt == 1 && cyc == 0) begin
				cls = instr_info.cls;
				two = instr_info.two_byte;
				ncyc = cls == 2 ? 4 : (cls == 0 ? 1 : 2);
				eir = opb;
			end
			if (cnt == 7 && cyc == 0 && two == 1) eopd = opd;
			if (cnt == 11) cyc = (cyc + 1 == ncyc) ? 0 : cyc + 1;
			cnt = (cnt == 11) ? 0 : cnt + 1;
		end
	end

	always @(negedge ref_clk) begin
		if (rst_n) begin
			chk_seq(phase_count, cnt[3:0]);
			chk_seq(phase_clk, cnt[0]);
			chk_seq(ale, cnt inside {1, 2, 7, 8});
			chk_seq(fetch, (cnt == 1 || cnt == 7) && !xm);
			chk_seq(xstb, xm);
			chk_seq(pc_inc, cyc == 0 && (cnt == 1 || (cnt == 7 && two == 1)));
			chk_seq(exec_done, cnt == 11 && cyc == ncyc - 1);
			chk_seq(instr_reg, eir);
			chk_seq(operand_q, eopd);
			if (cnt == 0 && cyc == 0) begin
				instr_info = sfr_bank_pkg::instr_info_t'(idx[2:0]);
				idx++;
			end
			if (cnt == 9) begin
				opb = $random(seed);
				opd = $random(seed);
			end
		end
	end

	// ==========================================
	// Tasks
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %0t value %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_seq(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %0t timing %h exp %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [1:0] m);
		@(negedge ref_clk);
		sfr_req = '{wr: w, rd: !w, indirect: m[1], pin: m[0], addr: a,
			wdata: d};
		@(negedge ref_clk);
		rdat = sfr_rdata;
		txs = tx_start;
		sfr_req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] m,
		input logic [7:0] e);
		xfer(1'b0, a, 8'h00, m);
		chk_val(rdat, e);
	endtask

	task automatic bxfer(input logic w, input logic [7:0] a, input logic d);
		@(negedge ref_clk);
		bit_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge ref_clk);
		brd = bit_rdata;
		bit_req = '0;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		trig = 1'b1;
		push_req = 1'b0;
		pop_req = 1'b0;
		data_pointer_load = 1'b0;
		data_pointer_inc = 1'b0;
		rx_load = 1'b0;
		sfr_req = '0;
		bit_req = '0;
		instr_info = '0;
		alu_flags = '0;
		data_pointer_val = 16'h0000;
		rx_byte = 8'h00;
		port_pin = $random(seed);
		// Zero first opcode: sync flops may still hold reset value
		opb = 8'h00;
		opd = 8'h00;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		for (i = 0; i < 26; i++) begin
			v = (regs[i][3:0] == 4'h0 && regs[i] <= 8'hb0) ? 8'hff : 8'h00;
			if (regs[i] == 8'h81) v = 8'h07;
			rd(regs[i], 2'b00, v);
		end
		for (i = 0; i < 26; i++) begin
			if (regs[i] != 8'h99 && regs[i] != 8'hd0) begin
				v = $random(seed);
				// Timer 2 kept stopped so its count reads back stable
				if (regs[i] == 8'hc8) v[2] = 1'b0;
				shadow[regs[i]] = v;
				xfer(1'b1, regs[i], v, 2'b00);
				rd(regs[i], 2'b00, v);
			end
		end
		chk_val(port_latch, {shadow[8'hb0], shadow[8'ha0], shadow[8'h90],
			shadow[8'h80]});
		chk_val(dp, {shadow[8'h83], shadow[8'h82]});
		chk_val(t0, {shadow[8'h8c], shadow[8'h8a]});
		chk_val(t1, {shadow[8'h8d], shadow[8'h8b]});
		chk_val(t2, {shadow[8'hcd], shadow[8'hcc]});
		for (i = 0; i < 3; i++) begin
			v = i == 0 ? 8'h84 : (i == 1 ? 8'h8e : 8'hff);
			xfer(1'b1, v, 8'h5a, 2'b00);
			rd(v, 2'b00, 8'h00);
		end
		xfer(1'b1, 8'h81, 8'h33, 2'b10);
		rd(8'h81, 2'b10, 8'h00);
		rd(8'h81, 2'b00, shadow[8'h81]);
		xfer(1'b1, 8'h81, 8'h07, 2'b00);
		for (i = 0; i < 2; i++) begin
			@(negedge ref_clk);
			push_req = 1'b1;
			@(negedge ref_clk);
			push_req = 1'b0;
			chk_val(stack_addr, i + 8);
		end
		@(negedge ref_clk);
		pop_req = 1'b1;
		@(negedge ref_clk);
		pop_req = 1'b0;
		chk_val(stack_addr, 8'h09);
		rd(8'h81, 2'b00, 8'h08);
		@(negedge ref_clk);
		data_pointer_val = 16'h12ff;
		data_pointer_load = 1'b1;
		@(negedge ref_clk);
		data_pointer_load = 1'b0;
		data_pointer_inc = 1'b1;
		@(negedge ref_clk);
		data_pointer_inc = 1'b0;
		chk_val(dp, 16'h1300);
		xfer(1'b1, 8'h82, 8'h55, 2'b00);
		chk_val(dp, 16'h1355);
		rd(8'h83, 2'b00, 8'h13);
		v = $random(seed);
		xfer(1'b1, 8'h99, v, 2'b00);
		chk_val({txs, tx_data}, {1'b1, v});
		@(negedge ref_clk);
		rx_byte = ~v;
		rx_load = 1'b1;
		@(negedge ref_clk);
		rx_load = 1'b0;
		rd(8'h99, 2'b00, ~v);
		chk_val({tx_start, tx_data}, {1'b0, v});
		port_pin = $random(seed);
		repeat (3) @(negedge ref_clk);
		rd(8'h90, 2'b01, port_pin[15:8]);
		rd(8'h90, 2'b00, shadow[8'h90]);
		bxfer(1'b1, 8'he2, 1'b1);
		shadow[8'he0][2] = 1'b1;
		rd(8'he0, 2'b00, shadow[8'he0]);
		bxfer(1'b0, 8'he2, 1'b0);
		chk_val(brd, 1'b1);
		bxfer(1'b1, 8'hf9, 1'b1);
		bxfer(1'b0, 8'hf9, 1'b0);
		chk_val(brd, 1'b0);
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			xfer(1'b1, 8'he0, v, 2'b00);
			xfer(1'b1, 8'hd0, 8'(i * 8), 2'b00);
			chk_val(bank_base, i * 8);
			rd(8'hd0, 2'b00, 8'(i * 8) | {7'h00, ^v});
		end
		xfer(1'b1, 8'hd0, 8'hff, 2'b00);
		bxfer(1'b1, 8'hd1, 1'b1);
		rd(8'hd0, 2'b00, 8'hfc | {7'h00, ^v});
		@(negedge ref_clk);
		alu_flags = '{wr: 1'b1, cy: 1'b0, ac: 1'b1, ov: 1'b0};
		@(negedge ref_clk);
		alu_flags = '0;
		rd(8'hd0, 2'b00, 8'h78 | {7'h00, ^v});
		xfer(1'b1, 8'hc8, 8'h01, 2'b00);
		xfer(1'b1, 8'hcc, 8'h34, 2'b00);
		xfer(1'b1, 8'hcd, 8'h12, 2'b00);
		trig = 1'b0;
		repeat (4) @(negedge ref_clk);
		trig = 1'b1;
		rd(8'hca, 2'b00, 8'h34);
		rd(8'hcb, 2'b00, 8'h12);
		xfer(1'b1, 8'hcb, 8'h56, 2'b00);
		xfer(1'b1, 8'hca, 8'h78, 2'b00);
		xfer(1'b1, 8'hcc, 8'hff, 2'b00);
		xfer(1'b1, 8'hcd, 8'hff, 2'b00);
		xfer(1'b1, 8'hc8, 8'h04, 2'b00);
		for (i = 0; i < 30 && t2 === 16'hffff; i++) @(negedge ref_clk);
		if (i == 30) begin
			mismatches++;
			results();
		end
		chk_val(t2, 16'h5678);
		xfer(1'b1, 8'hc8, 8'h00, 2'b00);
		// Freeze: sequencer model must hold with the design
		clk_en = 1'b0;
		repeat (5) @(negedge ref_clk);
		clk_en = 1'b1;
		repeat (300) @(negedge ref_clk);
		results();
	end
endmodule
